/* src/aisr_pkg.sv */
// package of constants for the init/reset sequencer
package aisr_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] SOFTWARE_RESET_CONTROL_ADDR = 8'h00;
    localparam int         SW_RESET_BIT                = 0;
    localparam logic [7:0] SOFTWARE_RESET_CONTROL_RST  = 8'h00;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CAL_CYCLES      = 200000;
    localparam int FUSE_LOAD_CYCLES = 4;
    localparam int CAL_CNT_W       = 18;
    typedef enum logic [1:0] {AISR_IDLE, AISR_FUSE, AISR_CAL, AISR_READY} aisr_state_type;
endpackage : aisr_pkg

/* src/aisr_cal_counter.sv */
// down counter timing the power-up capacitor calibration
module aisr_cal_counter #(
    parameter int W = 18
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              done_o
);
    logic [W-1:0] count_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (load_i) begin
            count_reg <= value_i;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign done_o = (count_reg == '0) && !load_i;
endmodule : aisr_cal_counter

/* src/aisr_sequencer.sv */
// reset, fuse load and calibration sequencing of the converter core
// ----------------------------------------
// ----------------------------------------
module aisr_sequencer
    import aisr_pkg::*;
#(
    parameter int CAL_COUNT = CAL_CYCLES
) (
    input  wire logic       CLOCK_I,
    input  wire logic       RESET_I,
    input  wire logic       RESET_PIN_I,
    input  wire logic       REFERENCE_BUFFER_STRAP_I,
    input  wire logic       REG_WRITE_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output logic [7:0]      REG_RDATA_O,
    output logic            SERIAL_SELECT_ENABLE_READY_O,
    output logic            CALIBRATING_O,
    output logic            REGS_DEFAULT_LOAD_O,
    output logic            REFERENCE_BUFFER_SEL_O
);
    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    aisr_state_type state_reg;
    logic [7:0]     ctrl_reg;
    logic           pin_d_reg;
    logic [2:0]     fuse_cnt_reg;
    logic           cal_load;
    logic           cal_done;
    logic           sw_write;
    logic           pin_release;

    assign sw_write    = REG_WRITE_I && (REG_ADDR_I == SOFTWARE_RESET_CONTROL_ADDR)
                         && REG_WDATA_I[SW_RESET_BIT] && !RESET_PIN_I;
    // pin is taken as synchronous; falling edge ends the hardware reset
    assign pin_release = pin_d_reg && !RESET_PIN_I;

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= RESET_PIN_I;
        end
    end

    // self-clearing: the bit is visible one cycle, then drops with the reload
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || RESET_PIN_I) begin
            ctrl_reg <= SOFTWARE_RESET_CONTROL_RST;
        end else if (sw_write) begin
            ctrl_reg <= 8'h01;
        end else begin
            ctrl_reg <= SOFTWARE_RESET_CONTROL_RST;
        end
    end

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || RESET_PIN_I) begin
            state_reg <= AISR_IDLE;
        end else begin
            case (state_reg)
                AISR_IDLE: begin
                    if (pin_release) begin
                        state_reg <= AISR_FUSE;
                    end
                end
                AISR_FUSE: begin
                    if (fuse_cnt_reg == 3'(FUSE_LOAD_CYCLES - 1)) begin
                        state_reg <= AISR_CAL;
                    end
                end
                AISR_CAL: begin
                    if (cal_done) begin
                        state_reg <= AISR_READY;
                    end
                end
                AISR_READY: begin
                    if (sw_write) begin
                        state_reg <= AISR_FUSE;
                    end
                end
                default: state_reg <= AISR_IDLE;
            endcase
            if (sw_write && state_reg != AISR_READY && state_reg != AISR_IDLE) begin
                state_reg <= AISR_FUSE;
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || state_reg != AISR_FUSE || sw_write) begin
            fuse_cnt_reg <= 3'h0;
        end else begin
            fuse_cnt_reg <= fuse_cnt_reg + 3'h1;
        end
    end

    // calibration is counted from reset release, fuse load included
    assign cal_load = pin_release || (sw_write && state_reg != AISR_IDLE);

    aisr_cal_counter #(
        .W (CAL_CNT_W)
    ) i_aisr_cal_counter (
        .clk_i   (CLOCK_I),
        .rst_i   (RESET_I || RESET_PIN_I),
        .load_i  (cal_load),
        .value_i (CAL_CNT_W'(CAL_COUNT - 1)),
        .done_o  (cal_done)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            REG_RDATA_O                  <= 8'h00;
            SERIAL_SELECT_ENABLE_READY_O <= 1'b0;
            CALIBRATING_O                <= 1'b0;
            REGS_DEFAULT_LOAD_O          <= 1'b0;
            REFERENCE_BUFFER_SEL_O       <= 1'b0;
        end else begin
            REG_RDATA_O                  <= ctrl_reg;
            SERIAL_SELECT_ENABLE_READY_O <= (state_reg == AISR_READY) && !sw_write;
            CALIBRATING_O                <= (state_reg == AISR_CAL);
            REGS_DEFAULT_LOAD_O          <= (state_reg == AISR_FUSE) || RESET_PIN_I;
            // strap is latched at hardware reset release, clocked not async
            if (pin_release) begin
                REFERENCE_BUFFER_SEL_O <= REFERENCE_BUFFER_STRAP_I;
            end
        end
    end

    // ----------------------------------------
    // check helpers
    // ----------------------------------------
    // cycles since the calibration counter was last loaded; saturates so a long
    // idle stretch cannot wrap round and look like a fresh reload
    logic [CAL_CNT_W-1:0] since_load_reg;

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            since_load_reg <= '1;
        end else if (cal_load) begin
            since_load_reg <= '0;
        end else if (since_load_reg != '1) begin
            since_load_reg <= since_load_reg + 1'b1;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_release_fuse: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        pin_release |=> state_reg == AISR_FUSE)
        else $error("fuse load not started on reset release");
    a_fuse_to_cal: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (state_reg == AISR_FUSE && fuse_cnt_reg == 3'(FUSE_LOAD_CYCLES - 1)
         && !sw_write && !RESET_PIN_I) |=> state_reg == AISR_CAL)
        else $error("calibration did not follow fuse load");
    a_sw_clear: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        sw_write ##1 !sw_write |=> ctrl_reg == 8'h00)
        else $error("software reset bit not self cleared");
    a_sw_restart: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (sw_write && state_reg != AISR_IDLE) |=> state_reg == AISR_FUSE)
        else $error("software reset did not reload defaults");
    a_pin_idle: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        RESET_PIN_I |=> state_reg == AISR_IDLE && ctrl_reg == 8'h00)
        else $error("hardware reset did not clear state");
    a_ready_out: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        SERIAL_SELECT_ENABLE_READY_O |-> $past(state_reg) == AISR_READY)
        else $error("ready shown before calibration end");
    a_cal_flag: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (state_reg == AISR_CAL && !cal_done && !RESET_PIN_I && !sw_write)
        |=> state_reg == AISR_CAL)
        else $error("calibration left early");
    a_strap_latch: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        pin_release |=> REFERENCE_BUFFER_SEL_O == $past(REFERENCE_BUFFER_STRAP_I))
        else $error("strap not latched at release");
    a_sw_set: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        sw_write |=> ctrl_reg[SW_RESET_BIT])
        else $error("software reset bit not set by write");
    a_rdata_echo: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        ctrl_reg[SW_RESET_BIT] |=> REG_RDATA_O[SW_RESET_BIT])
        else $error("reset bit not shown on read data");
    a_cal_out: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (state_reg == AISR_CAL) |=> CALIBRATING_O)
        else $error("calibration flag missing");
    a_dflt_out: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (RESET_PIN_I || state_reg == AISR_FUSE) |=> REGS_DEFAULT_LOAD_O)
        else $error("default load flag missing");
    a_idle_hold: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (state_reg == AISR_IDLE && !pin_release)
        |=> state_reg == AISR_IDLE)
        else $error("sequence left idle without reset release");
    a_ready_time: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        $rose(SERIAL_SELECT_ENABLE_READY_O)
        |-> since_load_reg == CAL_CNT_W'(CAL_COUNT + 1))
        else $error("ready not one calibration span after reload");

    c_hw_ready: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
        state_reg == AISR_CAL ##1 state_reg == AISR_READY);
    c_sw_reset: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
        state_reg == AISR_READY && sw_write);
    c_hw_release: cover property (@(posedge CLOCK_I) disable iff (RESET_I) pin_release);
    c_sw_in_cal: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
        state_reg == AISR_CAL && sw_write);
    c_sw_in_fuse: cover property (@(posedge CLOCK_I) disable iff (RESET_I)
        state_reg == AISR_FUSE && sw_write);
endmodule : aisr_sequencer

/* bench/aisr_host_model.sv */
// host controller model: reset pin, strap and register writes
module aisr_host_model #(
    parameter int PWR_CYCLES = 20
) (
    input  wire logic       clk_i,
    output logic            reset_pin_o,
    output logic            strap_o,
    output logic            write_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reset_pin_o = 1'b0;
        strap_o     = 1'b0;
        write_o     = 1'b0;
        addr_o      = 8'hA5;
        wdata_o     = 8'h5A;
    end
    // ----------------------------------------
    // power-up sequence
    // ----------------------------------------
    task automatic power_up(input logic strap);
        repeat (PWR_CYCLES) @(posedge clk_i); // settle time scaled down to keep runs short
        #1 strap_o = strap;
        repeat (2) @(posedge clk_i);
        #1 reset_pin_o = 1'b1;
        repeat (10) @(posedge clk_i); // ten cycles are 1 us
        #1 reset_pin_o = 1'b0; // pin stays low until the next power_up call
    endtask : power_up
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #1 write_o = 1'b1;
        addr_o  = addr;
        wdata_o = data;
        @(posedge clk_i);
        #1 write_o = 1'b0;
        addr_o  = ~addr; // released bus shows no stale value
        wdata_o = ~data;
    endtask : write_reg
endmodule : aisr_host_model

/* bench/tb_aisr_sequencer.sv */
// self-checking testbench of the init/reset sequencer
module tb_aisr_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CAL = 20;
    logic       clk, rst, pin, strap, wr, ready, cal, dflt, sel;
    logic [7:0] addr, wdata, rdata;
    int         bad_count = 0;
    int         comparisons = 0;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk; // never stopped during calibration
    end
    aisr_host_model i_aisr_host_model (.clk_i(clk), .reset_pin_o(pin), .strap_o(strap),
        .write_o(wr), .addr_o(addr), .wdata_o(wdata));
    aisr_sequencer #(.CAL_COUNT(CAL)) i_aisr_sequencer (.CLOCK_I(clk), .RESET_I(rst),
        .RESET_PIN_I(pin), .REFERENCE_BUFFER_STRAP_I(strap), .REG_WRITE_I(wr),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .SERIAL_SELECT_ENABLE_READY_O(ready), .CALIBRATING_O(cal),
        .REGS_DEFAULT_LOAD_O(dflt), .REFERENCE_BUFFER_SEL_O(sel));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check
    // counts edges until ready, noting fuse load and calibration on the way;
    // skip is the number of edges already passed since the reset was taken
    task automatic wait_ready(input int skip);
        int   n;
        logic d_seen;
        logic c_seen;
        n = skip;
        d_seen = 1'b0;
        c_seen = 1'b0;
        while (ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
            if (dflt === 1'b1) d_seen = 1'b1;
            if (cal === 1'b1 && d_seen) c_seen = 1'b1;
        end
        if (n >= 200) begin
            bad_count++;
            $display("ERROR at %0t: ready never came", $time);
            end_sim();
        end else begin
            check(8'(n >= CAL && n <= CAL + 4), 8'h01, "ready delay");
            check({6'h00, d_seen, c_seen}, 8'h03, "fuse load then calibration");
        end
    endtask : wait_ready
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        for (int s = 0; s < 2; s++) begin
            i_aisr_host_model.power_up(1'(s)); // second pass resets in operation
            wait_ready(0); // no writes before ready
            check({7'h00, sel}, 8'(s), "strap latch");
            check(rdata, 8'h00, "control default");
            $display("test hardware reset strap %0d done", s);
        end
        i_aisr_host_model.write_reg(8'h05, 8'h01);
        i_aisr_host_model.write_reg(8'h00, 8'hFE);
        repeat (3) @(posedge clk);
        #1 check({7'h00, ready}, 8'h01, "ignored writes");
        $display("test refused writes done");
        for (int k = 0; k < 2; k++) begin
            i_aisr_host_model.write_reg(8'h00, 8'h01);
            check({7'h00, ready}, 8'h00, "software reset drops ready");
        end
        @(posedge clk);
        #1 check(rdata, 8'h01, "reset bit visible");
        repeat (2) @(posedge clk);
        #1 check(rdata, 8'h00, "reset bit self clears");
        wait_ready(4); // wait again before programming
        $display("test software reset done");
        i_aisr_host_model.write_reg(8'h00, 8'h01);
        repeat (6) @(posedge clk);
        #1 check({7'h00, cal}, 8'h01, "calibration after software reset");
        i_aisr_host_model.write_reg(8'h00, 8'h01); // restart mid calibration
        @(posedge clk);
        #1 check({7'h00, cal}, 8'h00, "calibration restarted");
        wait_ready(2);
        $display("test software reset during calibration done");
        end_sim();
    end
endmodule : tb_aisr_sequencer
